// ---- src/smp_pkg.sv ----
// Constants and carrier types for the sine-wave motor PWM block
package smp_pkg;
  // Register byte offsets
  localparam logic [12:0] OFF_POSITION_DETECT_CONTROL_A  = 13'h1FA0;
  localparam logic [12:0] OFF_POSITION_DETECT_CONTROL_B  = 13'h1FA1;
  localparam logic [12:0] OFF_PDSTAT = 13'h1FA2;
  localparam logic [12:0] OFF_SDLY   = 13'h1FA3;
  localparam logic [12:0] OFF_MODE_TIMER_CONTROL_A  = 13'h1FA4;
  localparam logic [12:0] OFF_MODE_TIMER_CONTROL_B  = 13'h1FA5;
  localparam logic [12:0] OFF_MCAPT  = 13'h1FA6;
  localparam logic [12:0] OFF_MODE_COMPARE_ONE   = 13'h1FA8;
  localparam logic [12:0] OFF_MODE_COMPARE_TWO   = 13'h1FAA;
  localparam logic [12:0] OFF_MODE_COMPARE_THREE   = 13'h1FAC;
  localparam logic [12:0] OFF_PWMA   = 13'h1FAE;
  localparam logic [12:0] OFF_PWMCK  = 13'h1FAF;
  localparam logic [12:0] OFF_OVLB   = 13'h1FB1;
  localparam logic [12:0] OFF_PHOUT  = 13'h1FB2;
  localparam logic [12:0] OFF_PCNT   = 13'h1FB4;
  localparam logic [12:0] OFF_PPRD   = 13'h1FB6;
  localparam logic [12:0] OFF_DUTYU  = 13'h1FB8;
  localparam logic [12:0] OFF_DUTYV  = 13'h1FBA;
  localparam logic [12:0] OFF_DUTYW  = 13'h1FBC;
  localparam logic [12:0] OFF_DEAD   = 13'h1FBE;
  localparam logic [12:0] OFF_EKEY   = 13'h1FBF;
  localparam logic [12:0] OFF_ANGA   = 13'h1FC0;
  localparam logic [12:0] OFF_ANGB   = 13'h1FC1;
  localparam logic [12:0] OFF_APER   = 13'h1FC2;
  localparam logic [12:0] OFF_ANGLE  = 13'h1FC4;
  localparam logic [12:0] OFF_VSCL   = 13'h1FC6;
  localparam logic [12:0] OFF_ACAP   = 13'h1FC8;
  localparam logic [12:0] OFF_SINE   = 13'h1FCA;
  // Field positions
  localparam int ANGA_TEN = 0, ANGA_ARITH = 1, ANGA_XFER = 2, ANGA_MOD = 3;
  localparam int ANGA_CK = 4, ANGA_ORDER = 6, ANGA_DIR = 7;
  localparam int ANGB_IRQSEL = 0, ANGB_SYNC = 1, ANGB_BUSY = 2, ANGB_SW = 3;
  localparam int PDA_EN = 0, PDA_UNM = 1, PDA_ONE = 3;
  localparam int PDA_T2 = 4, PDA_T3 = 5, PDA_GO = 6, PDA_STOP = 7;
  localparam int MTA_EN = 0, MTA_RPD = 1, MTA_RSW = 2, MTA_ROV = 3;
  localparam int MTA_RT3 = 4;
  localparam int MTB_CPD = 1, MTB_CSW = 2, MTB_COV = 3, MTB_OVF = 5;
  localparam int PWA_MODE = 1, PWA_IRQ = 2;
  localparam int PHO_SEL = 8, OVB_SYNC = 6, OVB_RET = 7;
  // Reset values and limits
  localparam logic [7:0]  ANGA_RST = 8'h00;
  localparam logic [15:0] APER_RST = 16'h0010;
  localparam logic [11:0] STEP_MIN = 12'h010;
  localparam logic [8:0]  ANG_LAST = 9'h17F;
  localparam logic [8:0]  ANG_HALF = 9'h0C0;
  localparam logic [8:0]  ANG_120  = 9'h080;
  localparam logic [8:0]  ANG_240  = 9'h100;
  localparam logic [7:0]  KEY_ONE  = 8'h5A;
  localparam logic [7:0]  KEY_TWO  = 8'hA5;
  localparam logic [5:0]  CALC_CYC = 6'd35;
  localparam int          PH_TICKS = 16;
  // Phase duties carried together
  typedef struct packed {
    logic [11:0] u;
    logic [11:0] v;
    logic [11:0] w;
  } smp_duty_t;
  typedef enum logic [1:0] {SMP_IDLE, SMP_CALC} smp_calc_t;
endpackage

// ---- src/smp_top.sv ----
// Sine-wave motor PWM controller with Avalon-MM register slave
// How it works
// - writing one to sw start begins calculation
// - busy bit reflects calculation in progress
// - sync select zero starts on angle events
// - angle irq at count end or calc end
// - direction bit seven chooses up or down
// - phase order picks plus or minus offsets
// - clock field divides fc by 8..64
// - modulation bit picks two or three phase
// - transfer enable copies results into duties
// - arithmetic enable gates all calculations
// - period is clock times 384 times m+n/16
// - twelve bit amplitude multiplies table data
// - sine port writes RAM at current angle
// - sampler started and stopped by sw or timers
// - three pins or U only; unmatch mode
// - 1 to 15 consecutive matches detect position
// - mode timer reset and capture by sources
// - pwm irq every 1,2,4,8 periods; two modes
// - output select gives level or pwm
// - emergency disabled only after key 5A, A5
// - overload return bit, optional pwm sync
// - two phase product; three phase half period
// - duty writes ignored while transfer enabled
// - timer enable clear stops and zeroes angle
`timescale 1ns/1ns
`default_nettype none
module smp_top (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [12:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [7:0]  avs_writedata_i,
  output logic      [7:0]  avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [2:0]  position_i,
  input  wire logic        overload_i,
  input  wire logic        emergency_stop_i,
  input  wire logic        timer1_evt_i,
  input  wire logic        timer2_evt_i,
  input  wire logic        timer3_evt_i,
  output logic      [5:0]  motor_driver_o,
  output logic             angle_irq_o,
  output logic             pwm_irq_o
);
  import smp_pkg::*;

  // Byte-lane access of a 16-bit register pair
  function automatic logic [15:0] wr16(input logic [15:0] cur,
                                       input logic hi, input logic [7:0] d);
    wr16 = hi ? {d, cur[7:0]} : {cur[15:8], d};
  endfunction

  // Synchronisers for pins
  logic [2:0] pos_s1_r, pos_s2_r;
  logic [4:0] evt_s1_r, evt_s2_r;
  always_ff @(posedge clk_sys_i) begin
    pos_s1_r <= position_i;
    pos_s2_r <= pos_s1_r;
    evt_s1_r <= {emergency_stop_i, overload_i, timer3_evt_i,
                 timer2_evt_i, timer1_evt_i};
    evt_s2_r <= evt_s1_r;
  end
  logic [4:0] evt_d_r;
  always_ff @(posedge clk_sys_i) evt_d_r <= evt_s2_r;
  wire [4:0] evt_rise = evt_s2_r & ~evt_d_r;
  wire t1_ev = evt_rise[0];
  wire t2_ev = evt_rise[1];
  wire t3_ev = evt_rise[2];
  wire ovl_ev = evt_rise[3];
  wire emg_ev = evt_rise[4];

  // Bus strobes: one-cycle waitrequest on reads, writes take at once
  logic rd_ack_r;
  wire wr = avs_write_i;
  wire [12:0] a = avs_address_i;
  wire [12:0] aw = {a[12:1], 1'b0};
  wire hi = a[0];
  wire [7:0] d = avs_writedata_i;
  wire wr_anga = wr && a == OFF_ANGA;
  wire wr_angb = wr && a == OFF_ANGB;
  wire wr_ang  = wr && aw == OFF_ANGLE;
  wire wr_sine = wr && a == OFF_SINE;
  wire wr_pda  = wr && a == OFF_POSITION_DETECT_CONTROL_A;
  wire wr_mta  = wr && a == OFF_MODE_TIMER_CONTROL_A;
  wire wr_mtb  = wr && a == OFF_MODE_TIMER_CONTROL_B;
  wire wr_duty = wr && (aw == OFF_DUTYU || aw == OFF_DUTYV ||
                        aw == OFF_DUTYW);
  wire wr_key  = wr && a == OFF_EKEY;
  wire wr_ovb  = wr && a == OFF_OVLB;

  // Plain storage registers
  logic [7:0]  anga_r, angb_r, pda_r, pdb_r, sdly_r, mta_r, mtb_r;
  logic [7:0]  pwa_r, pwck_r, ovb_r, dead_r;
  logic [15:0] aper_r, vscl_r, mode_compare_one_r, mode_compare_two_r, mode_compare_three_r, phout_r, pprd_r;
  smp_duty_t   duty_r;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      anga_r <= ANGA_RST; angb_r <= '0; pda_r <= '0; pdb_r <= 8'h01;
      sdly_r <= '0; mta_r <= '0; mtb_r <= '0; pwa_r <= '0;
      pwck_r <= '0; ovb_r <= '0; dead_r <= '0; aper_r <= APER_RST;
      vscl_r <= '0; mode_compare_one_r <= '0; mode_compare_two_r <= '0; mode_compare_three_r <= '0;
      phout_r <= '0; pprd_r <= 16'h0100;
    end else if (wr) begin
      unique case (aw)
        OFF_POSITION_DETECT_CONTROL_A:  if (hi) pdb_r <= d; else pda_r <= d & 8'h3F;
        OFF_PDSTAT: if (hi) sdly_r <= d & 8'h7F;
        OFF_MODE_TIMER_CONTROL_A:  if (hi) mtb_r <= d & 8'h8A;
                    else mta_r <= d & 8'hFB;
        OFF_MODE_COMPARE_ONE:   mode_compare_one_r <= wr16(mode_compare_one_r, hi, d);
        OFF_MODE_COMPARE_TWO:   mode_compare_two_r <= wr16(mode_compare_two_r, hi, d);
        OFF_MODE_COMPARE_THREE:   mode_compare_three_r <= wr16(mode_compare_three_r, hi, d);
        OFF_PWMA:   if (hi) pwck_r <= d & 8'h03; else pwa_r <= d;
        OFF_PHOUT:  phout_r <= wr16(phout_r, hi, d) & 16'h7FFF;
        OFF_PPRD:   pprd_r <= wr16(pprd_r, hi, d) & 16'h0FFF;
        OFF_APER:   aper_r <= wr16(aper_r, hi, d);
        OFF_VSCL:   vscl_r <= wr16(vscl_r, hi, d) & 16'h0FFF;
        OFF_DEAD:   if (!hi) dead_r <= d & 8'h3F;
        OFF_ANGA:   if (hi) angb_r <= d & 8'h03; else anga_r <= d;
        OFF_OVLB - 13'h1: if (hi) ovb_r <= d & 8'h40;
        default: ;
      endcase
    end
  end

  // Angle timer: prescaler, step counter and correction
  logic [5:0]  pre_r;
  logic [12:0] step_r;
  logic [3:0]  sub_r;
  logic [8:0]  ang_r;
  wire [1:0]  cksel = anga_r[ANGA_CK +: 2];
  wire [5:0]  pre_max = 6'((8 << cksel) - 1);
  wire        tick = pre_r == pre_max;
  wire [11:0] m_raw = aper_r[11:0];
  wire [11:0] m_val = (m_raw < STEP_MIN) ? STEP_MIN : m_raw;
  wire [3:0]  n_val = aper_r[15:12];
  // Add one extra tick to each of the last n steps in every 16 steps
  wire [4:0]  acc = {1'b0, sub_r} + {1'b0, n_val};
  wire        add1 = acc[4] | (acc[3:0] < sub_r);
  wire [12:0] step_end = {1'b0, m_val} - 13'd1 + {12'd0, add1};
  wire        ang_ev = anga_r[ANGA_TEN] && tick && step_r >= step_end;
  wire        down = anga_r[ANGA_DIR];
  wire [8:0]  ang_next = down ? (ang_r == 9'd0 ? ANG_LAST : ang_r - 9'd1)
                              : (ang_r == ANG_LAST ? 9'd0 : ang_r + 9'd1);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !anga_r[ANGA_TEN]) begin
      pre_r <= '0; step_r <= '0; sub_r <= '0;
      if (srst_i) ang_r <= '0;
      else if (wr_ang && !hi) ang_r <= {ang_r[8], d};
      else if (wr_ang && hi) ang_r <= {d[0], ang_r[7:0]};
    end else begin
      pre_r <= tick ? 6'd0 : pre_r + 6'd1;
      if (ang_ev) begin
        step_r <= '0;
        sub_r <= sub_r + 4'd1;
      end else if (tick) step_r <= step_r + 13'd1;
      if (wr_anga && !d[ANGA_TEN]) ang_r <= '0;
      else if (wr_ang && !hi) ang_r <= {ang_r[8], d};
      else if (wr_ang && hi) ang_r <= {d[0], ang_r[7:0]};
      else if (ang_ev) ang_r <= ang_next;
    end
  end
  wire [8:0] ang_lim = ang_r > ANG_LAST ? ANG_LAST : ang_r;

  // Sine table storage
  logic [7:0] sine_r [0:383];
  always_ff @(posedge clk_sys_i) begin
    if (wr_sine) sine_r[ang_lim] <= d;
  end

  // Waveform arithmetic sequencer
  smp_calc_t   cst_r;
  logic [5:0]  ccnt_r;
  logic        cdone_r;
  smp_duty_t   res_r;
  wire arith_on = anga_r[ANGA_ARITH];
  wire sw_go = wr_angb && d[ANGB_SW];
  wire sync_go = !angb_r[ANGB_SYNC] && (ang_ev || wr_ang);
  wire go = arith_on && (sw_go || sync_go);
  // Phase angle offsets
  function automatic logic [8:0] ofs(input logic [8:0] b,
                                     input logic [8:0] o, input logic neg);
    logic [9:0] s;
    s = neg ? {1'b0, b} + 10'd384 - {1'b0, o} : {1'b0, b} + {1'b0, o};
    ofs = s >= 10'd384 ? 9'(s - 10'd384) : s[8:0];
  endfunction
  function automatic logic [11:0] wave(input logic [8:0] ph);
    logic [19:0] p;
    logic [11:0] h;
    p = 20'(sine_r[ph]) * 20'(vscl_r[11:0]);
    h = pprd_r[12:1];
    if (!anga_r[ANGA_MOD]) wave = p[19:8];
    else if (ph < ANG_HALF) wave = 12'(h + p[19:9]);
    else wave = 12'(h - p[19:9]);
  endfunction
  wire       ord = anga_r[ANGA_ORDER];
  wire [8:0] ph_v = ofs(ang_lim, ANG_120, ord);
  wire [8:0] ph_w = ofs(ang_lim, ANG_240, ord);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cst_r <= SMP_IDLE; ccnt_r <= '0; cdone_r <= 1'b0; res_r <= '0;
    end else begin
      cdone_r <= 1'b0;
      if (go) begin
        cst_r <= SMP_CALC; ccnt_r <= '0;
      end else if (!arith_on) cst_r <= SMP_IDLE;
      else unique case (cst_r)
        SMP_IDLE: ;
        SMP_CALC: if (ccnt_r == CALC_CYC - 6'd1) begin
          cst_r <= SMP_IDLE; cdone_r <= 1'b1;
          res_r <= '{wave(ang_lim), wave(ph_v), wave(ph_w)};
        end else ccnt_r <= ccnt_r + 6'd1;
      endcase
    end
  end
  wire busy = cst_r == SMP_CALC;
  // Cycles since the running calculation began, for the length check
  logic [6:0] blen_r;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || go || !busy) blen_r <= '0;
    else blen_r <= blen_r + 7'd1;
  end

  // Duty compare registers
  wire xfer = anga_r[ANGA_XFER] && arith_on;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) duty_r <= '0;
    else if (xfer && cdone_r) duty_r <= res_r;
    else if (wr_duty && !anga_r[ANGA_XFER]) begin
      if (aw == OFF_DUTYU) duty_r.u <= 12'(wr16(16'(duty_r.u), hi, d));
      if (aw == OFF_DUTYV) duty_r.v <= 12'(wr16(16'(duty_r.v), hi, d));
      if (aw == OFF_DUTYW) duty_r.w <= 12'(wr16(16'(duty_r.w), hi, d));
    end
  end

  // Position sampler and detector
  logic       samp_r, det_r;
  logic [3:0] mcnt_r;
  logic [2:0] last_r, ref_r;
  wire [2:0]  cmp_mask = pda_r[PDA_ONE] ? 3'b001 : 3'b111;
  wire [2:0]  target = phout_r[14:12];
  wire        match = pda_r[PDA_UNM]
                      ? ((pos_s2_r & cmp_mask) != (ref_r & cmp_mask))
                      : ((pos_s2_r & cmp_mask) == (target & cmp_mask));
  wire [3:0]  need = pdb_r[3:0] == 4'd0 ? 4'd1 : pdb_r[3:0];
  wire        detect = samp_r && match && mcnt_r + 4'd1 >= need;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      samp_r <= 1'b0; mcnt_r <= '0; last_r <= '0; ref_r <= '0;
      det_r <= 1'b0;
    end else begin
      det_r <= detect;
      if (wr_pda && (d[PDA_STOP] || !d[PDA_EN])) samp_r <= 1'b0;
      else if (pda_r[PDA_T3] && t3_ev) samp_r <= 1'b0;
      else if (wr_pda && d[PDA_GO] && d[PDA_EN]) samp_r <= 1'b1;
      else if (pda_r[PDA_EN] && pda_r[PDA_T2] && t2_ev) samp_r <= 1'b1;
      else if (detect) samp_r <= 1'b0;
      if (!samp_r) begin
        mcnt_r <= '0; ref_r <= pos_s2_r;
      end else if (match) mcnt_r <= mcnt_r + 4'd1;
      else mcnt_r <= '0;
      last_r <= pos_s2_r;
    end
  end

  // Angle capture
  logic [8:0] acap_r;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) acap_r <= '0;
    else if (detect) acap_r <= ang_r;
  end

  // Mode timer
  logic [15:0] mt_r, mode_timer_capture_r;
  logic [6:0]  mpre_r;
  logic        movf_r;
  wire [2:0]  mck = mta_r[7:5];
  wire [6:0]  mpre_max = mck == 3'b001 ? 7'd127
                       : 7'((8 << mck[2:1]) - 1);
  wire mt_rst = (wr_mta && d[MTA_RSW]) || (mta_r[MTA_RPD] && detect) ||
                (mta_r[MTA_ROV] && ovl_ev) || (mta_r[MTA_RT3] && t3_ev);
  wire mt_cap = (wr_mtb && d[MTB_CSW]) || (mtb_r[MTB_CPD] && detect) ||
                (mtb_r[MTB_COV] && ovl_ev);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mt_r <= '0; mode_timer_capture_r <= '0; mpre_r <= '0; movf_r <= 1'b0;
    end else begin
      if (mt_cap) mode_timer_capture_r <= mt_r;
      if (mt_rst || !mta_r[MTA_EN]) begin
        mt_r <= '0; mpre_r <= '0;
      end else if (mpre_r >= mpre_max) begin
        mpre_r <= '0; mt_r <= mt_r + 16'd1;
        if (mt_r == 16'hFFFF) movf_r <= 1'b1;
      end else mpre_r <= mpre_r + 7'd1;
    end
  end

  // PWM counter, irq divider, phase outputs
  logic [11:0] pc_r;
  logic        pdn_r;
  logic [3:0]  ppre_r;
  logic [2:0]  pwm_irq_rate_r;
  logic [5:0]  drv_r;
  logic        pirq_r, airq_r;
  wire [3:0]  ppre_max = 4'((2 << pwck_r[1:0]) - 1);
  wire        ptick = ppre_r == ppre_max;
  wire        tri_m = pwa_r[PWA_MODE];
  wire        pend = ptick && (tri_m ? (pdn_r && pc_r <= 12'd1)
                                     : pc_r >= pprd_r[11:0] - 12'd1);
  wire [2:0]  pwm_irq_rate_max = 3'((1 << pwa_r[PWA_IRQ +: 2]) - 1);
  wire [2:0]  duty_on = {pc_r < duty_r.w, pc_r < duty_r.v, pc_r < duty_r.u};
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !pwa_r[0]) begin
      pc_r <= '0; pdn_r <= 1'b0; ppre_r <= '0; pwm_irq_rate_r <= '0;
      pirq_r <= 1'b0;
    end else begin
      ppre_r <= ptick ? 4'd0 : ppre_r + 4'd1;
      pirq_r <= pend && pwm_irq_rate_r == pwm_irq_rate_max;
      if (pend) pwm_irq_rate_r <= pwm_irq_rate_r == pwm_irq_rate_max ? 3'd0 : pwm_irq_rate_r + 3'd1;
      if (ptick) begin
        if (!tri_m) pc_r <= pend ? 12'd0 : pc_r + 12'd1;
        else if (pend) begin
          pdn_r <= 1'b0; pc_r <= '0;
        end else if (!pdn_r && pc_r >= pprd_r[11:0] - 12'd1) begin
          pdn_r <= 1'b1; pc_r <= pc_r - 12'd1;
        end else pc_r <= pdn_r ? pc_r - 12'd1 : pc_r + 12'd1;
      end
    end
  end

  // Emergency key and protective states
  logic       key1_r, emg_en_r, emg_st_r, ovl_st_r;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      key1_r <= 1'b0; emg_en_r <= 1'b1; emg_st_r <= 1'b0;
      ovl_st_r <= 1'b0;
    end else begin
      if (wr_key) begin
        key1_r <= d == KEY_ONE;
        if (key1_r && d == KEY_TWO) emg_en_r <= 1'b0;
      end
      if (emg_en_r && emg_ev) emg_st_r <= 1'b1;
      if (ovl_ev) ovl_st_r <= 1'b1;
      else if ((wr_ovb && d[OVB_RET]) ||
               (ovb_r[OVB_SYNC] && pend && ovl_st_r && !evt_s2_r[3]))
        ovl_st_r <= 1'b0;
    end
  end

  // Drive outputs from flip-flops
  genvar g;
  for (g = 0; g < 3; g++) begin : g_phase
    always_ff @(posedge clk_sys_i) begin
      if (srst_i || emg_st_r || ovl_st_r) drv_r[2*g +: 2] <= 2'b00;
      else if (phout_r[PHO_SEL + g])
        drv_r[2*g +: 2] <= {duty_on[g], ~duty_on[g]};
      else drv_r[2*g +: 2] <= phout_r[2*g +: 2];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) airq_r <= 1'b0;
    else airq_r <= angb_r[ANGB_IRQSEL] ? cdone_r : ang_ev;
  end

  // Read mux
  logic [15:0] rv;
  always_comb begin
    unique case (aw)
      OFF_POSITION_DETECT_CONTROL_A:  rv = {pdb_r, pda_r};
      OFF_PDSTAT: rv = {sdly_r, 4'h0, samp_r, last_r};
      OFF_MODE_TIMER_CONTROL_A:  rv = {mtb_r | {2'b00, movf_r, 5'h00}, mta_r};
      OFF_MCAPT:  rv = mode_timer_capture_r;
      OFF_MODE_COMPARE_ONE:   rv = mode_compare_one_r;
      OFF_MODE_COMPARE_TWO:   rv = mode_compare_two_r;
      OFF_MODE_COMPARE_THREE:   rv = mode_compare_three_r;
      OFF_PWMA:   rv = {pwck_r, pwa_r};
      OFF_OVLB - 13'h1: rv = {ovb_r | {3'b000, ovl_st_r, 4'h0},
                              5'h00, emg_st_r, 1'b0, emg_en_r};
      OFF_PHOUT:  rv = {pdn_r, phout_r[14:0]};
      OFF_PCNT:   rv = {4'h0, pc_r};
      OFF_PPRD:   rv = pprd_r;
      OFF_DUTYU:  rv = {4'h0, duty_r.u};
      OFF_DUTYV:  rv = {4'h0, duty_r.v};
      OFF_DUTYW:  rv = {4'h0, duty_r.w};
      OFF_DEAD:   rv = {8'h00, dead_r};
      OFF_ANGA:   rv = {4'h0, angb_r[3], busy, angb_r[1:0], anga_r};
      OFF_APER:   rv = aper_r;
      OFF_ANGLE:  rv = {7'h00, ang_r};
      OFF_VSCL:   rv = vscl_r;
      OFF_ACAP:   rv = {7'h00, acap_r};
      default:    rv = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_ack_r <= 1'b0; avs_readdata_o <= '0;
      motor_driver_o <= '0; angle_irq_o <= 1'b0; pwm_irq_o <= 1'b0;
    end else begin
      rd_ack_r <= avs_read_i && !rd_ack_r;
      if (avs_read_i && !rd_ack_r) avs_readdata_o <= hi ? rv[15:8] : rv[7:0];
      motor_driver_o <= drv_r;
      angle_irq_o <= airq_r;
      pwm_irq_o <= pirq_r;
    end
  end
  assign avs_waitrequest_o = avs_read_i && !rd_ack_r;

  // Checks
  a_busy_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    go |=> busy) else $error("calc did not start");
  a_calc_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    busy && !go && arith_on |=>
    busy == ($past(blen_r) != 7'(CALC_CYC) - 7'd1))
    else $error("calc length");
  a_calc_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !arith_on |=> !cdone_r) else $error("calc while off");
  a_timer_clr: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    anga_r[ANGA_TEN] && wr_anga && !d[ANGA_TEN] |=> ang_r == 9'd0)
    else $error("angle not cleared");
  a_angle_wrap: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ang_ev && !wr_ang && !down && ang_r == ANG_LAST |=> ang_r == 9'd0)
    else $error("angle wrap");
  a_duty_lock: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    anga_r[ANGA_XFER] && !cdone_r |=> $stable(duty_r))
    else $error("duty written in transfer");
  a_capture_ang: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    detect |=> acap_r == $past(ang_r)) else $error("angle capture");
  a_emg_key: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(emg_en_r) |-> $past(key1_r) && $past(d) == KEY_TWO)
    else $error("emergency key");
  a_angle_irq: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !angb_r[ANGB_IRQSEL] && ang_ev |-> ##2 angle_irq_o)
    else $error("angle irq");
endmodule // smp_top
`default_nettype wire

// ---- test/smp_stage_model.sv ----
// Behavioural inverter stage and rotor sensor model for the motor block
`timescale 1ns/1ns
`default_nettype none
module smp_stage_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] drive_i,
  input  wire logic       step_i,
  output var  logic [2:0] position_o,
  output logic            overload_o
);
  // Sensor code moves one sector per commanded step
  initial position_o = 3'h1;
  always @(posedge clk_i) begin
    if (step_i) position_o <= {position_o[1:0], position_o[2]};
  end
  // A leg with both switches on shorts the supply and trips overload
  assign overload_o = (drive_i[5] & drive_i[4]) | (drive_i[3] & drive_i[2])
                    | (drive_i[1] & drive_i[0]);
endmodule // smp_stage_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the sine-wave motor PWM block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module tb_top;
  import smp_pkg::*;
  logic        clk_sys, wreq, airq, pirq, ovl;
  logic        srst = 1'b1, rd = 1'b0, wr = 1'b0, step = 1'b0;
  logic [12:0] adr = 13'h0000;
  logic [7:0]  wd = 8'h00, rdat, v, a8, d;
  logic [15:0] w16;
  logic [11:0] ex;
  logic [2:0]  pos;
  logic [5:0]  drv;
  int          miscompares = 0, n_tests = 0, nirq = 0, npirq = 0, st, k, ix;

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Count one-cycle angle and PWM interrupt pulses
  always @(posedge clk_sys) begin
    if (airq === 1'b1) nirq <= nirq + 1;
    if (pirq === 1'b1) npirq <= npirq + 1;
  end
  // Block under test and its far side
  smp_top uut (
    .clk_sys_i(clk_sys), .srst_i(srst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .position_i(pos),
    .overload_i(ovl), .emergency_stop_i(1'b0), .timer1_evt_i(1'b0),
    .timer2_evt_i(1'b0), .timer3_evt_i(1'b0), .motor_driver_o(drv),
    .angle_irq_o(airq), .pwm_irq_o(pirq)
  );
  smp_stage_model u_stage (.clk_i(clk_sys), .drive_i(drv), .step_i(step),
    .position_o(pos), .overload_o(ovl));

  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus transfer held until waitrequest is sampled low
  task automatic bus(input logic [12:0] a, input logic w, input logic [7:0] x);
    int n;
    @(posedge clk_sys);
    {adr, wd, wr, rd} <= {a, x, w, ~w};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (wreq === 1'b0) break;
    end
    v = rdat;
    {wr, rd} <= 2'b00;
    if (n == 20) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // Sixteen-bit registers go low byte first
  task automatic wr16(input logic [12:0] a, input logic [15:0] x);
    bus(a, 1'b1, x[7:0]);
    bus(a + 13'h0001, 1'b1, x[15:8]);
  endtask
  task automatic rd16(input logic [12:0] a);
    bus(a, 1'b0, 8'h00);
    w16[7:0] = v;
    bus(a + 13'h0001, 1'b0, 8'h00);
    w16[15:8] = v;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    bus(OFF_ANGA, 1'b0, 8'h00);
    `CHK(v, ANGA_RST)
    rd16(OFF_APER);
    `CHK(w16, APER_RST)
    bus(13'h1FCE, 1'b0, 8'h00);
    `CHK(v, 8'h00)
    // Duty write taken, then refused while transfer is on
    wr16(OFF_DUTYU, 16'h0123);
    bus(OFF_ANGA, 1'b1, 8'h04);
    wr16(OFF_DUTYU, 16'h0055);
    rd16(OFF_DUTYU);
    `CHK(w16, 16'h0123)
    // Three table entries loaded with arithmetic off
    bus(OFF_ANGA, 1'b1, 8'h00);
    for (ix = 0; ix < 3; ix++) begin
      wr16(OFF_ANGLE, 16'(ix * 128));
      bus(OFF_SINE, 1'b1, 8'h40 >> ix);
    end
    wr16(OFF_ANGLE, 16'h0000);
    wr16(OFF_VSCL, 16'h0200);
    // Each modulation and phase order, started by software
    for (k = 0; k < 4; k++) begin
      a8 = {1'b0, k[1], 2'b00, k[0], 3'b110};
      bus(OFF_ANGA, 1'b1, a8);
      bus(OFF_ANGB, 1'b1, 8'h0A);
      bus(OFF_ANGB, 1'b0, 8'h00);
      `CHK(v[2], 1'b1)
      for (ix = 0; ix < 40 && v[2] !== 1'b0; ix++) bus(OFF_ANGB, 1'b0, 8'h00);
      `CHK(v[2], 1'b0)
      for (ix = 0; ix < 3; ix++) begin
        st = (ix == 0 || k[1] == 1'b0) ? ix : 3 - ix;
        d = 8'h40 >> st;
        ex = k[0] ? (st == 2 ? 12'h080 - d : 12'h080 + d) : {3'b000, d, 1'b0};
        rd16(OFF_DUTYU + 13'(2 * ix));
        `CHK(w16[11:0], ex)
      end
    end
    // Angle timer rate and direction for each clock code
    bus(OFF_ANGA, 1'b1, 8'h00);
    for (k = 0; k < 4; k++) begin
      a8 = {k[0], 1'b0, k[1:0], 4'h0};
      wr16(OFF_ANGLE, 16'h0000);
      bus(OFF_ANGA, 1'b1, a8);
      bus(OFF_ANGA, 1'b1, a8 | 8'h01);
      nirq = 0;
      repeat (600) @(posedge clk_sys);
      st = 600 / (128 << k);
      `CHK(nirq, st)
      rd16(OFF_ANGLE);
      `CHK(w16, k[0] ? 16'((384 - st) % 384) : 16'(st))
      bus(OFF_ANGA, 1'b1, a8);
      rd16(OFF_ANGLE);
      `CHK(w16, 16'h0000)
    end
    // Emergency circuit stays on until the key pair arrives in order
    for (k = 0; k < 2; k++) begin
      bus(OFF_EKEY, 1'b1, k ? KEY_ONE : KEY_TWO);
      bus(OFF_EKEY, 1'b1, k ? KEY_TWO : KEY_ONE);
      bus(13'h1FB0, 1'b1, 8'h00);
      bus(13'h1FB0, 1'b0, 8'h00);
      `CHK(v[0], k == 0)
    end
    // Sampler started by software while the rotor turns
    bus(OFF_POSITION_DETECT_CONTROL_A, 1'b1, 8'h41);
    step <= 1'b1;
    bus(OFF_PDSTAT, 1'b0, 8'h00);
    step <= 1'b0;
    `CHK(v[3], 1'b1)
    // Matching the rotor code stops sampling and captures the angle
    wr16(OFF_ANGLE, 16'h0123);
    bus(OFF_PHOUT + 13'h0001, 1'b1, 8'h10);
    rd16(OFF_ACAP);
    `CHK(w16, 16'h0123)
    bus(OFF_PDSTAT, 1'b0, 8'h00);
    `CHK(v[3], 1'b0)
    // Fixed levels reach the pins; a shorted leg trips overload
    bus(OFF_PHOUT, 1'b1, 8'h24);
    repeat (3) @(posedge clk_sys);
    `CHK(drv, 6'h24)
    bus(OFF_PHOUT, 1'b1, 8'h03);
    repeat (10) @(posedge clk_sys);
    `CHK(drv, 6'h00)
    bus(OFF_PHOUT, 1'b1, 8'h01);
    bus(OFF_OVLB, 1'b1, 8'h80);
    repeat (3) @(posedge clk_sys);
    `CHK(drv, 6'h01)
    // A 16-count sawtooth at fc/2 fires the PWM irq every 32 cycles
    wr16(OFF_PPRD, 16'h0010);
    bus(OFF_PWMA, 1'b1, 8'h01);
    npirq = 0;
    repeat (330) @(posedge clk_sys);
    `CHK(npirq, 330 / 32)
    report_and_stop();
  end
  // Guard against a hung run
  initial begin
    #4000000;
    miscompares++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
